// >>> rst_init_pkg.sv
// What this block does
// - A wake-up from sleep sets at least one interrupt flag naming its cause.
// - Interrupt wake-up with a global enable set loads vector 0008h or 0018h.
// - That wake-up pushes the program counter into the top of stack, advancing the pointer.
// - Port-A bits 6 and 7 exist only when the oscillator mode frees them; else read zero.
// - Power-on and external resets clear the upper analog-select register when the port-B analog default is zero.
// - Unimplemented bits always read zero and ignore writes.
// - Power-on and external resets clear the return stack pointer to zero, a location without storage; a wake does not.
package rst_init_pkg;
    localparam logic [3:0] ADDR_CTRL    = 4'h0;
    localparam logic [3:0] ADDR_STATUS  = 4'h1;
    localparam logic [3:0] ADDR_IRQ_EN  = 4'h2;
    localparam logic [3:0] ADDR_IRQ_CLR = 4'h3;
    localparam logic [3:0] ADDR_PCFLAG  = 4'h4;
    localparam logic [3:0] ADDR_PORT_A_INPUT   = 4'h5;
    localparam logic [3:0] ADDR_PORT_A_OUTPUT_LATCH    = 4'h6;
    localparam logic [3:0] ADDR_PORT_A_DIRECTION   = 4'h7;
    localparam logic [3:0] ADDR_ANSH    = 4'h8;
    localparam logic [3:0] ADDR_PC      = 4'h9;
    localparam logic [3:0] ADDR_TOS     = 4'hA;
    localparam logic [3:0] ADDR_SP      = 4'hB;

    localparam logic [20:0] VEC_HIGH   = 21'h000008;
    localparam logic [20:0] VEC_LOW    = 21'h000018;
    localparam logic [7:0]  PORT_A_DIRECTION_RST  = 8'hFF;
    localparam logic [7:0]  PORT_A_OUTPUT_LATCH_RST   = 8'h00;
    localparam logic [4:0]  ANSH_RST   = 5'h1F;
    localparam logic [4:0]  ANSH_MASK  = 5'h1F;
    localparam logic [7:0]  PIR_RST    = 8'h00;
    localparam logic [7:0]  PIR1_MASK  = 8'h7F;
    localparam logic [4:0]  SP_RST     = 5'h00;
    localparam logic [7:0]  PA_LOW_MASK = 8'h3F;
    localparam int          EVT_W      = 4;
    localparam int          EV_POR     = 0;
    localparam int          EV_EXT     = 1;
    localparam int          EV_WAKE    = 2;
    localparam int          EV_VECT    = 3;

    typedef enum logic [1:0] {
        CLS_NONE,
        CLS_POR,
        CLS_EXT,
        CLS_WAKE
    } reset_class_t;

    typedef struct packed {
        logic       por;
        logic       ext;
        logic       wake;
        logic       wake_irq;
        logic       wake_hi;
        logic [7:0] wake_flags;
        logic       wake_pir2;
    } cause_t;

    typedef struct packed {
        logic       osc_frees_ra67;
        logic       port_b_analog_default;
    } fuses_t;

    typedef struct packed {
        logic        valid;
        logic [20:0] pc;
    } vector_req_t;
endpackage

// >>> sticky_bit.sv
`timescale 1ns/100ps
`default_nettype none
module sticky_bit (
    input  wire logic clk_in,
    input  wire logic rst_b_in,
    input  wire logic set_in,
    input  wire logic clr_in,
    output logic      q_out
);
    // A set in the same cycle as a clear wins, so no event is lost.
    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            q_out <= 1'b0;
        end else begin
            q_out <= set_in | (q_out & ~clr_in);
        end
    end
endmodule // sticky_bit
`default_nettype wire

// >>> reset_init_wake_vector.sv
// Our own choices: the register addresses and register access over Avalon-MM.
`timescale 1ns/100ps
`default_nettype none
module reset_init_wake_vector (
    input  wire logic                      clk_in,
    input  wire logic                      rst_b_in,
    input  wire rst_init_pkg::cause_t      cause_in,
    input  wire rst_init_pkg::fuses_t      fuses_in,
    input  wire logic [7:0]                port_a_input_pins_in,
    input  wire logic [3:0]                avs_address_in,
    input  wire logic                      avs_read_in,
    input  wire logic                      avs_write_in,
    input  wire logic [31:0]               avs_writedata_in,
    output logic [31:0]                    avs_readdata_out,
    output logic                           avs_waitrequest_out,
    output rst_init_pkg::vector_req_t      vector_out,
    output logic [7:0]                     port_a_direction_out,
    output logic [7:0]                     port_a_output_latch_out,
    output logic [4:0]                     upper_analog_select_out,
    output logic [4:0]                     return_stack_pointer_out,
    output logic                           irq_out
);
    import rst_init_pkg::*;

    logic [20:0]        pc_ff;
    logic [20:0]        tos_ff;
    logic [4:0]         sp_ff;
    logic [7:0]         pir1_ff;
    logic [7:0]         pir2_ff;
    logic [7:0]         port_a_direction_ff;
    logic [7:0]         port_a_output_latch_ff;
    logic [4:0]         ansh_ff;
    logic               gie_hi_ff;
    logic               gie_lo_ff;
    logic [EVT_W-1:0]   irq_en_ff;
    logic [EVT_W-1:0]   status_w;
    logic               ack_ff;
    logic               wreq_ff;
    logic [31:0]        rdata_ff;
    reset_class_t       cls_w;
    logic               vec_go_w;
    logic [20:0]        vec_pc_w;
    logic [7:0]         pa_mask_w;
    logic               wr_w;
    logic               rd_w;
    logic [EVT_W-1:0]   evt_w;
    logic [EVT_W-1:0]   clr_w;
    logic [31:0]        nxt_rdata;

    // Classify the incoming reset cause; power-on outranks external, which outranks wake.
    assign cls_w = cause_in.por  ? CLS_POR  :
                   cause_in.ext  ? CLS_EXT  :
                   cause_in.wake ? CLS_WAKE : CLS_NONE;
    // Vectoring only when the wake came from an interrupt and some global enable is set.
    assign vec_go_w = (cls_w == CLS_WAKE) && cause_in.wake_irq
                      && (gie_hi_ff || gie_lo_ff);
    assign vec_pc_w = cause_in.wake_hi ? VEC_HIGH : VEC_LOW;
    // Bits 6 and 7 vanish unless the oscillator mode leaves those pins free.
    assign pa_mask_w = fuses_in.osc_frees_ra67 ? 8'hFF : PA_LOW_MASK;

    // Bus decode: a single-cycle wait then the answer, for reads and writes alike.
    assign wr_w = avs_write_in && ack_ff;
    assign rd_w = avs_read_in && ack_ff;
    assign evt_w[EV_POR]  = (cls_w == CLS_POR);
    assign evt_w[EV_EXT]  = (cls_w == CLS_EXT);
    assign evt_w[EV_WAKE] = (cls_w == CLS_WAKE);
    assign evt_w[EV_VECT] = vec_go_w;
    assign clr_w = (wr_w && avs_address_in == ADDR_IRQ_CLR) ?
                   avs_writedata_in[EVT_W-1:0] : '0;

    genvar gi;
    generate
        for (gi = 0; gi < EVT_W; gi++) begin : g_evt
            sticky_bit u_sticky (
                .clk_in   (clk_in),
                .rst_b_in (rst_b_in),
                .set_in   (evt_w[gi]),
                .clr_in   (clr_w[gi]),
                .q_out    (status_w[gi])
            );
        end
    endgenerate

    // Read mux; unimplemented bits read zero and unmapped offsets read zero.
    always_comb begin
        nxt_rdata = 32'h00000000;
        unique case (avs_address_in)
            ADDR_CTRL:    nxt_rdata = {30'h0, gie_hi_ff, gie_lo_ff};
            ADDR_STATUS:  nxt_rdata = {28'h0, status_w};
            ADDR_IRQ_EN:  nxt_rdata = {28'h0, irq_en_ff};
            ADDR_PCFLAG:  nxt_rdata = {16'h0, pir2_ff, pir1_ff & PIR1_MASK};
            ADDR_PORT_A_INPUT:   nxt_rdata = {24'h0, port_a_input_pins_in & pa_mask_w};
            ADDR_PORT_A_OUTPUT_LATCH:    nxt_rdata = {24'h0, port_a_output_latch_ff & pa_mask_w};
            ADDR_PORT_A_DIRECTION:   nxt_rdata = {24'h0, port_a_direction_ff & pa_mask_w};
            ADDR_ANSH:    nxt_rdata = {27'h0, ansh_ff & ANSH_MASK};
            ADDR_PC:      nxt_rdata = {11'h0, pc_ff};
            ADDR_TOS:     nxt_rdata = {11'h0, tos_ff};
            ADDR_SP:      nxt_rdata = {27'h0, sp_ff};
            default:      nxt_rdata = 32'h00000000;
        endcase
    end

    // Handshake: waitrequest drops for one cycle after each request is seen.
    // The inverted copy is its own flop so the pin carries no gate after the register.
    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            ack_ff   <= 1'b0;
            wreq_ff  <= 1'b1;
            rdata_ff <= 32'h00000000;
        end else begin
            ack_ff   <= (avs_read_in || avs_write_in) && !ack_ff;
            wreq_ff  <= !((avs_read_in || avs_write_in) && !ack_ff);
            rdata_ff <= rd_w ? rdata_ff : nxt_rdata;
        end
    end
    assign avs_readdata_out    = rdata_ff;
    assign avs_waitrequest_out = wreq_ff;

    // Control and interrupt enable registers survive every reset class.
    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            gie_hi_ff <= 1'b0;
            gie_lo_ff <= 1'b0;
            irq_en_ff <= '0;
        end else if (wr_w && avs_address_in == ADDR_CTRL) begin
            gie_hi_ff <= avs_writedata_in[1];
            gie_lo_ff <= avs_writedata_in[0];
        end else if (wr_w && avs_address_in == ADDR_IRQ_EN) begin
            irq_en_ff <= avs_writedata_in[EVT_W-1:0];
        end
    end

    // Flags: cleared by power-on and external resets, set by the wake cause.
    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            pir1_ff <= PIR_RST;
            pir2_ff <= PIR_RST;
        end else if (cls_w == CLS_POR || cls_w == CLS_EXT) begin
            pir1_ff <= PIR_RST;
            pir2_ff <= PIR_RST;
        end else if (cls_w == CLS_WAKE) begin
            // An empty flag set still marks a wake, so bit 0 stands in as the cause.
            if (cause_in.wake_pir2) begin
                pir2_ff <= pir2_ff | ((cause_in.wake_flags == 8'h00) ?
                           8'h01 : cause_in.wake_flags);
            end else begin
                pir1_ff <= pir1_ff | (((cause_in.wake_flags & PIR1_MASK) == 8'h00) ?
                           8'h01 : (cause_in.wake_flags & PIR1_MASK));
            end
        end else if (wr_w && avs_address_in == ADDR_PCFLAG) begin
            pir1_ff <= avs_writedata_in[7:0] & PIR1_MASK;
            pir2_ff <= avs_writedata_in[15:8];
        end
    end

    // Port A direction and latch; the latch keeps its value across power-on, external and wake reset classes.
    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            port_a_direction_ff <= PORT_A_DIRECTION_RST;
            port_a_output_latch_ff  <= PORT_A_OUTPUT_LATCH_RST;
        end else if (cls_w == CLS_POR || cls_w == CLS_EXT) begin
            port_a_direction_ff <= PORT_A_DIRECTION_RST;
        end else if (wr_w && avs_address_in == ADDR_PORT_A_DIRECTION) begin
            port_a_direction_ff <= avs_writedata_in[7:0] & pa_mask_w;
        end else if (wr_w && avs_address_in == ADDR_PORT_A_OUTPUT_LATCH) begin
            port_a_output_latch_ff  <= avs_writedata_in[7:0] & pa_mask_w;
        end
    end

    // Upper analog select; the fuse is sampled by the clock when a power-on or external reset class arrives.
    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            ansh_ff <= ANSH_RST;
        end else if (cls_w == CLS_POR || cls_w == CLS_EXT) begin
            ansh_ff <= fuses_in.port_b_analog_default ? ANSH_RST : 5'h00;
        end else if (wr_w && avs_address_in == ADDR_ANSH) begin
            ansh_ff <= avs_writedata_in[4:0] & ANSH_MASK;
        end
    end

    // Program counter, top of stack and pointer; a vectoring wake pushes the old PC.
    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            pc_ff  <= 21'h000000;
            tos_ff <= 21'h000000;
            sp_ff  <= SP_RST;
        end else if (cls_w == CLS_POR || cls_w == CLS_EXT) begin
            pc_ff  <= 21'h000000;
            sp_ff  <= SP_RST;
        end else if (vec_go_w) begin
            tos_ff <= pc_ff;
            sp_ff  <= sp_ff + 5'h01;
            pc_ff  <= vec_pc_w;
        end else if (wr_w && avs_address_in == ADDR_PC) begin
            pc_ff  <= {avs_writedata_in[20:1], 1'b0};  // Word aligned fetches only.
        end else if (wr_w && avs_address_in == ADDR_TOS) begin
            tos_ff <= avs_writedata_in[20:0];
        end else if (wr_w && avs_address_in == ADDR_SP) begin
            sp_ff  <= avs_writedata_in[4:0];
        end
    end

    // Registered outputs toward the core and the pins.
    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            vector_out               <= '0;
            port_a_direction_out     <= PORT_A_DIRECTION_RST;
            port_a_output_latch_out  <= PORT_A_OUTPUT_LATCH_RST;
            upper_analog_select_out  <= ANSH_RST;
            return_stack_pointer_out <= SP_RST;
            irq_out                  <= 1'b0;
        end else begin
            vector_out.valid         <= vec_go_w;
            vector_out.pc            <= vec_pc_w;
            port_a_direction_out     <= port_a_direction_ff & pa_mask_w;
            port_a_output_latch_out  <= port_a_output_latch_ff & pa_mask_w;
            upper_analog_select_out  <= ansh_ff;
            return_stack_pointer_out <= sp_ff;
            irq_out                  <= |(status_w & irq_en_ff);
        end
    end
endmodule // reset_init_wake_vector
`default_nettype wire

// >>> rst_init_chk_sva.sv
`timescale 1ns/100ps
`default_nettype none
module rst_init_chk (
    input wire logic                      clk_in,
    input wire logic                      rst_b_in,
    input wire rst_init_pkg::cause_t      cause_in,
    input wire rst_init_pkg::fuses_t      fuses_in,
    input wire logic                      avs_write_in,
    input wire rst_init_pkg::vector_req_t vector_out,
    input wire logic [7:0]                port_a_direction_out,
    input wire logic [7:0]                port_a_output_latch_out,
    input wire logic [4:0]                upper_analog_select_out,
    input wire logic [4:0]                return_stack_pointer_out
);
    import rst_init_pkg::*;
    // Everything here lives in the one clock domain, so clocking and reset are shared.
    default clocking @(posedge clk_in); endclocking
    default disable iff (!rst_b_in);
    // A vectoring pulse must trace back to an interrupt wake one cycle earlier.
    vec_addr_a: assert property (vector_out.valid |->
        vector_out.pc == ($past(cause_in.wake_hi) ? VEC_HIGH : VEC_LOW)) else $error("bad vector");
    vec_cause_a: assert property (vector_out.valid |->
        $past(cause_in.wake) && $past(cause_in.wake_irq)) else $error("vector without wake");
    stack_push_a: assert property (vector_out.valid |=>
        return_stack_pointer_out == $past(return_stack_pointer_out) + 5'h01) else $error("no push");
    // Reset classes other than wake pull the pointer and the direction bits back.
    // The pointer and pin outputs are registered copies, so they settle two edges on.
    stack_clear_a: assert property (cause_in.por || cause_in.ext |-> ##2
        return_stack_pointer_out == SP_RST) else $error("pointer not cleared");
    analog_clear_a: assert property ((cause_in.por || cause_in.ext) &&
        !fuses_in.port_b_analog_default |-> ##2 upper_analog_select_out == 5'h00)
        else $error("analog select not cleared");
    dir_reset_a: assert property (cause_in.por || cause_in.ext |-> ##2 port_a_direction_out ==
        ($past(fuses_in.osc_frees_ra67) ? 8'hFF : 8'h3F)) else $error("direction not reset");
    wake_keep_a: assert property (cause_in.wake && !cause_in.por && !cause_in.ext &&
        !avs_write_in |=> $stable(port_a_direction_out)) else $error("wake changed direction");
    // The first cycle after a fuse change may still carry the old mask.
    top_bits_off_a: assert property (!fuses_in.osc_frees_ra67 &&
        !$past(fuses_in.osc_frees_ra67) && $past(rst_b_in) |-> port_a_direction_out[7:6] == 2'h0
        && port_a_output_latch_out[7:6] == 2'h0) else $error("port bits 6 and 7 live");
endmodule // rst_init_chk
bind reset_init_wake_vector rst_init_chk chk_u (.clk_in, .rst_b_in, .cause_in, .fuses_in,
    .avs_write_in, .vector_out, .port_a_direction_out, .port_a_output_latch_out,
    .upper_analog_select_out, .return_stack_pointer_out);
`default_nettype wire

// >>> cpu_stack_model.sv
`timescale 1ns/100ps
`default_nettype none
module cpu_stack_model (
    input wire logic                      clk_in,
    input wire logic                      rst_b_in,
    input wire rst_init_pkg::vector_req_t vector_in,
    output logic [20:0]                   fetch_pc_out,
    output logic [7:0]                    taken_count_out
);
    // The core fetches from the reset vector until a vectoring pulse redirects it.
    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            fetch_pc_out <= 21'h000000;
            taken_count_out <= 8'h00;
        end else if (vector_in.valid) begin
            fetch_pc_out <= vector_in.pc;
            taken_count_out <= taken_count_out + 8'h01;
        end
    end
endmodule // cpu_stack_model
`default_nettype wire

// >>> tb.sv
`timescale 1ns/100ps
`default_nettype none
module tb;
    import rst_init_pkg::*;
    logic        clk_in = 1'b0;
    logic        rst_b_in = 1'b0;
    cause_t      cause = '0;
    fuses_t      fuses = 2'h3;
    logic [7:0]  pins = 8'h00;
    logic [3:0]  addr = 4'h0;
    logic        rd = 1'b0;
    logic        wr = 1'b0;
    logic [31:0] wdata = 32'h0;
    logic [31:0] rdata, q;
    logic        wreq, irq, hi;
    vector_req_t vec;
    logic [7:0]  dir, lat, cnt;
    logic [4:0]  ans, sp;
    logic [20:0] fpc, old_pc;
    int          fail_count = 0;
    int          tests_run = 0;
    int          seed = 67;
    int          sp_exp = 0;
    // Free-running 200 MHz clock.
    always #2.5 clk_in = ~clk_in;
    reset_init_wake_vector dut_u (.clk_in(clk_in), .rst_b_in(rst_b_in), .cause_in(cause),
        .fuses_in(fuses), .port_a_input_pins_in(pins), .avs_address_in(addr), .avs_read_in(rd),
        .avs_write_in(wr), .avs_writedata_in(wdata), .avs_readdata_out(rdata),
        .avs_waitrequest_out(wreq), .vector_out(vec), .port_a_direction_out(dir),
        .port_a_output_latch_out(lat), .upper_analog_select_out(ans),
        .return_stack_pointer_out(sp), .irq_out(irq));
    cpu_stack_model model_u (.clk_in(clk_in), .rst_b_in(rst_b_in), .vector_in(vec),
        .fetch_pc_out(fpc), .taken_count_out(cnt));
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            fail_count++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic close_out();
        $display("mismatches %0d in %0d checks", fail_count, tests_run);
        if (fail_count == 0 && tests_run > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    // The request is held until waitrequest is seen low; 20 cycles without it end the test as a failure.
    task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk_in);
        addr <= a;
        wdata <= d;
        wr <= w;
        rd <= !w;
        do begin
            @(posedge clk_in);
            n++;
        end while (wreq !== 1'b0 && n < 20);
        q = rdata;
        wr <= 1'b0;
        rd <= 1'b0;
        if (n >= 20) begin
            fail_count++;
            close_out();
        end
    endtask
    task automatic rdchk(input logic [3:0] a, input logic [31:0] exp);
        bus(1'b0, a, 32'h0);
        check(q, exp);
    endtask
    // One-cycle reset-class pulse; kind bits are power-on, external, wake.
    task automatic pulse(input logic [2:0] k, input logic ir, input logic h, input logic [7:0] f);
        @(posedge clk_in);
        cause <= {k, ir, h, f, 1'b0};
        @(posedge clk_in);
        cause <= '0;
        repeat (2) @(posedge clk_in);
    endtask
    function automatic logic [7:0] pa(input logic [7:0] v);
        return fuses.osc_frees_ra67 ? v : v & PA_LOW_MASK;
    endfunction
    function automatic logic [20:0] vec_of(input logic h);
        return h ? VEC_HIGH : VEC_LOW;
    endfunction
    // Main sequence.
    initial begin
        repeat (2) @(posedge clk_in);
        rst_b_in <= 1'b1;
        rdchk(ADDR_PORT_A_DIRECTION, {24'h0, pa(PORT_A_DIRECTION_RST)});
        rdchk(ADDR_SP, 32'h0);
        rdchk(4'hF, 32'h0);
        bus(1'b1, ADDR_STATUS, 32'hF);
        rdchk(ADDR_STATUS, 32'h0);
        bus(1'b1, ADDR_IRQ_EN, 32'h4);
        pulse(3'b001, 1'b1, 1'b0, 8'hFF);
        rdchk(ADDR_PCFLAG, 32'h7F);
        check(irq, 1'b1);
        check(cnt, 8'h00);
        bus(1'b1, ADDR_IRQ_CLR, 32'h4);
        bus(1'b1, ADDR_IRQ_EN, 32'h0);
        repeat (2) @(negedge clk_in);
        check(irq, 1'b0);
        // Enabled wakes from random program counters, both priorities.
        for (int i = 0; i < 6; i++) begin
            old_pc = 21'($random(seed)) & 21'h1FFFFE;
            hi = 1'($random(seed));
            bus(1'b1, ADDR_CTRL, {30'h0, 2'(i % 3 + 1)});
            bus(1'b1, ADDR_PC, {11'h0, old_pc | 21'h1});
            pulse(3'b001, 1'b1, hi, 8'h01);
            sp_exp++;
            check(fpc, vec_of(hi));
            rdchk(ADDR_TOS, {11'h0, old_pc});
            rdchk(ADDR_SP, sp_exp);
        end
        check(cnt, 8'h06);
        check(irq, 1'b0);
        bus(1'b1, ADDR_IRQ_EN, 32'h8);
        repeat (2) @(negedge clk_in);
        check(irq, 1'b1);
        fuses <= 2'h2;
        pulse(3'b010, 1'b0, 1'b0, 8'h00);
        rdchk(ADDR_SP, 32'h0);
        rdchk(ADDR_ANSH, 32'h0);
        fuses <= 2'h3;
        pulse(3'b100, 1'b0, 1'b0, 8'h00);
        rdchk(ADDR_ANSH, {27'h0, ANSH_RST});
        // Oscillator mode that takes pins 6 and 7, so they read zero.
        fuses <= 2'h1;
        pins <= 8'($random(seed));
        bus(1'b1, ADDR_PORT_A_OUTPUT_LATCH, 32'hFF);
        rdchk(ADDR_PORT_A_OUTPUT_LATCH, 32'h3F);
        rdchk(ADDR_PORT_A_INPUT, {24'h0, pa(pins)});
        pulse(3'b010, 1'b0, 1'b0, 8'h00);
        check(lat, 8'h3F);
        check(dir, 8'h3F);
        close_out();
    end
    // Hang guard.
    initial begin
        repeat (20000) @(posedge clk_in);
        fail_count++;
        close_out();
    end
endmodule // tb
`default_nettype wire
